// ### ccp_pkg.sv
package ccp_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // register map
    localparam logic [ADDR_W-1:0] PLL_CTRL_ADDR = 10'h010;
    localparam logic [ADDR_W-1:0] DIV_RATIO_ADDR = 10'h1e0;
    localparam logic [ADDR_W-1:0] SRC_SEL_ADDR = 10'h1e1;
    localparam logic [ADDR_W-1:0] NVM_STATUS_ADDR = 10'h3f0;
    localparam logic [ADDR_W-1:0] NVM_CMD_ADDR = 10'h3f1;

    // values after power-up or reset when no valid image is stored
    localparam logic [DATA_W-1:0] PLL_CTRL_RESET = 8'h01;
    localparam logic [DATA_W-1:0] DIV_RATIO_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SRC_SEL_RESET = 8'h00;

    // field positions and encodings
    localparam int PLL_PWR_LSB = 0;
    localparam int PFD_POL_BIT = 7;
    localparam int DIV_RATIO_LSB = 0;
    localparam int DIV_RATIO_W = 3;
    localparam int SRC_BYPASS_BIT = 0;
    localparam int SRC_DIVSEL_BIT = 1;
    localparam logic [1:0] PLL_PWR_NORMAL = 2'h0;
    localparam logic [1:0] PLL_PWR_DOWN = 2'h1;
    localparam int NVM_CMD_STORE_BIT = 0;
    localparam int NVM_ST_VALID_BIT = 0;
    localparam int NVM_ST_BUSY_BIT = 1;

    // nonvolatile store timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int NVM_STORE_TIME_NS = 400;
    localparam int NVM_STORE_CYCLES = (NVM_STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // image order: {source select, divider ratio, pll control}
    typedef logic [3*DATA_W-1:0] ccp_image_type;

    typedef enum logic [1:0]
    {
        SEQ_RESTORE = 2'h0,
        SEQ_IDLE = 2'h1,
        SEQ_STORE = 2'h3
    } ccp_seq_state_type;
endpackage

// ### ccp_nvm_if.sv
`timescale 1ns/1ps
interface ccp_nvm_if;
    logic store_req;
    ccp_pkg::ccp_image_type store_image;
    ccp_pkg::ccp_image_type stored_image;
    logic stored_valid;

    modport ctrl
    (
        output store_req,
        output store_image,
        input stored_image,
        input stored_valid
    );
    modport store
    (
        input store_req,
        input store_image,
        output stored_image,
        output stored_valid
    );
endinterface

// ### ccp_nvm_store.sv
`timescale 1ns/1ps
// on-board nonvolatile image; survives reset_in, invalidated only by nvm_blank_in, which clears the valid flag and keeps the image bits
module ccp_nvm_store
(
    input wire logic core_clk_in,
    input wire logic nvm_blank_in,
    ccp_nvm_if.store nvm
);
    ccp_pkg::ccp_image_type image;
    ccp_pkg::ccp_image_type next_image;
    logic valid;
    logic next_valid;

    always_comb
    begin
        next_image = image;
        next_valid = valid;
        if (nvm_blank_in)
        begin
            next_valid = 1'b0;
        end
        else if (nvm.store_req)
        begin
            next_image = nvm.store_image;
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        image <= next_image;
        valid <= next_valid;
    end

    assign nvm.stored_image = image;
    assign nvm.stored_valid = valid;
endmodule

// ### ccp_clock_path_cfg.sv
`timescale 1ns/1ps
module ccp_clock_path_cfg
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic nvm_blank_in,
    input wire logic [ccp_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [ccp_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic reg_ready_out,
    output logic [ccp_pkg::DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic pll_power_down_out,
    output logic pll_normal_out,
    output logic pfd_negative_out,
    output logic [ccp_pkg::DIV_RATIO_W-1:0] divider_ratio_code_out,
    output logic divider_bypass_out,
    output logic clk_source_sel_out,
    output logic prescaler_feed_out,
    output logic nvm_busy_out
);
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] STORE_LAST = CNT_W'(ccp_pkg::NVM_STORE_CYCLES - 1);

    initial
    begin
        if (ccp_pkg::NVM_STORE_CYCLES < 1 || ccp_pkg::NVM_STORE_CYCLES > 255)
        begin
            $error("store cycle count does not fit the counter");
        end
    end

    ccp_nvm_if nvm_if ();

    ccp_nvm_store u_nvm
    (
        .core_clk_in(core_clk_in),
        .nvm_blank_in(nvm_blank_in),
        .nvm(nvm_if.store)
    );

    ccp_pkg::ccp_seq_state_type state;
    ccp_pkg::ccp_seq_state_type next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [ccp_pkg::DATA_W-1:0] pll_ctrl;
    logic [ccp_pkg::DATA_W-1:0] next_pll_ctrl;
    logic [ccp_pkg::DATA_W-1:0] div_ratio;
    logic [ccp_pkg::DATA_W-1:0] next_div_ratio;
    logic [ccp_pkg::DATA_W-1:0] src_sel;
    logic [ccp_pkg::DATA_W-1:0] next_src_sel;
    logic [ccp_pkg::DATA_W-1:0] next_rdata;
    logic wr_ok;
    logic [1:0] pll_pwr;

    assign reg_ready_out = (state == ccp_pkg::SEQ_IDLE);
    assign wr_ok = reg_write_in && reg_ready_out;

    // register file, restore and store sequencing
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_pll_ctrl = pll_ctrl;
        next_div_ratio = div_ratio;
        next_src_sel = src_sel;
        case (state)
            ccp_pkg::SEQ_RESTORE:
            begin
                if (nvm_if.stored_valid)
                begin
                    next_pll_ctrl = nvm_if.stored_image[ccp_pkg::DATA_W-1:0];
                    next_div_ratio = nvm_if.stored_image[2*ccp_pkg::DATA_W-1:ccp_pkg::DATA_W];
                    next_src_sel = nvm_if.stored_image[3*ccp_pkg::DATA_W-1:2*ccp_pkg::DATA_W];
                end
                next_state = ccp_pkg::SEQ_IDLE;
            end
            ccp_pkg::SEQ_IDLE:
            begin
                if (wr_ok)
                begin
                    case (reg_addr_in)
                        ccp_pkg::PLL_CTRL_ADDR: next_pll_ctrl = reg_wdata_in;
                        ccp_pkg::DIV_RATIO_ADDR: next_div_ratio = reg_wdata_in;
                        ccp_pkg::SRC_SEL_ADDR: next_src_sel = reg_wdata_in;
                        ccp_pkg::NVM_CMD_ADDR:
                        begin
                            if (reg_wdata_in[ccp_pkg::NVM_CMD_STORE_BIT])
                            begin
                                next_state = ccp_pkg::SEQ_STORE;
                                next_cnt = STORE_LAST;
                            end
                        end
                        default: next_state = ccp_pkg::SEQ_IDLE;
                    endcase
                end
            end
            ccp_pkg::SEQ_STORE:
            begin
                if (cnt == '0)
                begin
                    next_state = ccp_pkg::SEQ_IDLE;
                end
                else
                begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: next_state = ccp_pkg::SEQ_IDLE;
        endcase
        if (reset_in)
        begin
            next_state = ccp_pkg::SEQ_RESTORE;
            next_cnt = '0;
            next_pll_ctrl = ccp_pkg::PLL_CTRL_RESET;
            next_div_ratio = ccp_pkg::DIV_RATIO_RESET;
            next_src_sel = ccp_pkg::SRC_SEL_RESET;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        state <= next_state;
        cnt <= next_cnt;
        pll_ctrl <= next_pll_ctrl;
        div_ratio <= next_div_ratio;
        src_sel <= next_src_sel;
    end

    // image is written on the last store cycle; writes are refused meanwhile
    assign nvm_if.store_req = (state == ccp_pkg::SEQ_STORE) && (cnt == '0);
    assign nvm_if.store_image = {src_sel, div_ratio, pll_ctrl};

    // read port, answered one cycle later; unmapped reads give zero
    always_comb
    begin
        next_rdata = '0;
        case (reg_addr_in)
            ccp_pkg::PLL_CTRL_ADDR: next_rdata = pll_ctrl;
            ccp_pkg::DIV_RATIO_ADDR: next_rdata = div_ratio;
            ccp_pkg::SRC_SEL_ADDR: next_rdata = src_sel;
            ccp_pkg::NVM_STATUS_ADDR:
            begin
                next_rdata[ccp_pkg::NVM_ST_VALID_BIT] = nvm_if.stored_valid;
                next_rdata[ccp_pkg::NVM_ST_BUSY_BIT] = (state == ccp_pkg::SEQ_STORE);
            end
            default: next_rdata = '0;
        endcase
        if (reset_in || !reg_read_in)
        begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        reg_rdata_out <= next_rdata;
        reg_rvalid_out <= reg_read_in && !reset_in;
    end

    // decoded clock path controls
    assign pll_pwr = pll_ctrl[ccp_pkg::PLL_PWR_LSB +: 2];
    assign pll_power_down_out = (pll_pwr == ccp_pkg::PLL_PWR_DOWN);
    assign pll_normal_out = (pll_pwr == ccp_pkg::PLL_PWR_NORMAL);
    assign pfd_negative_out = pll_ctrl[ccp_pkg::PFD_POL_BIT];
    assign divider_ratio_code_out = div_ratio[ccp_pkg::DIV_RATIO_LSB +: ccp_pkg::DIV_RATIO_W];
    assign divider_bypass_out = src_sel[ccp_pkg::SRC_BYPASS_BIT];
    assign clk_source_sel_out = !src_sel[ccp_pkg::SRC_BYPASS_BIT];
    assign prescaler_feed_out = pll_normal_out;
    assign nvm_busy_out = (state == ccp_pkg::SEQ_STORE);

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_store_cmd;
        wr_ok && reg_addr_in == ccp_pkg::NVM_CMD_ADDR && reg_wdata_in[ccp_pkg::NVM_CMD_STORE_BIT];
    endsequence

    sequence s_store_run;
        nvm_busy_out [*8] ##1 !nvm_busy_out;
    endsequence

    sequence s_reset_release;
        reset_in ##1 (!reset_in && nvm_if.stored_valid);
    endsequence

    a_reset_defaults: assert property (@(posedge core_clk_in) disable iff (1'b0)
        reset_in |=> pll_power_down_out && !divider_bypass_out && clk_source_sel_out
            && divider_ratio_code_out == 3'h0)
        else $error("reset defaults not loaded");
    a_pll_off_write: assert property (wr_ok && reg_addr_in == ccp_pkg::PLL_CTRL_ADDR
        && reg_wdata_in[1:0] == 2'h1 |=> pll_power_down_out && !pll_normal_out)
        else $error("pll not powered down");
    a_pll_on_write: assert property (wr_ok && reg_addr_in == ccp_pkg::PLL_CTRL_ADDR
        && reg_wdata_in[1:0] == 2'h0 |=> pll_normal_out && prescaler_feed_out)
        else $error("pll not in normal operation");
    a_pfd_polarity: assert property (wr_ok && reg_addr_in == ccp_pkg::PLL_CTRL_ADDR
        |=> pfd_negative_out == $past(reg_wdata_in[7]))
        else $error("pfd polarity wrong");
    a_bypass_select: assert property (wr_ok && reg_addr_in == ccp_pkg::SRC_SEL_ADDR
        |=> divider_bypass_out == $past(reg_wdata_in[0])
            && clk_source_sel_out != divider_bypass_out)
        else $error("divider bypass or source select wrong");
    a_div_ratio: assert property (wr_ok && reg_addr_in == ccp_pkg::DIV_RATIO_ADDR
        |=> divider_ratio_code_out == $past(reg_wdata_in[2:0]))
        else $error("divider ratio code wrong");
    a_store_length: assert property (s_store_cmd |=> s_store_run)
        else $error("store busy time wrong");
    a_restore_image: assert property (@(posedge core_clk_in) disable iff (1'b0)
        s_reset_release |=> {src_sel, div_ratio, pll_ctrl} == $past(nvm_if.stored_image))
        else $error("stored image not restored");
    a_store_refused: assert property (nvm_busy_out && reg_write_in
        |=> $stable({src_sel, div_ratio, pll_ctrl}))
        else $error("write taken during store");
endmodule

// ### ccp_host_model.sv
`timescale 1ns/1ps
module ccp_host_model
(
    input wire logic core_clk_in,
    input wire logic ready_in,
    input wire logic [ccp_pkg::DATA_W-1:0] rdata_in,
    input wire logic rvalid_in,
    output logic [ccp_pkg::ADDR_W-1:0] addr_out,
    output logic [ccp_pkg::DATA_W-1:0] wdata_out,
    output logic write_out,
    output logic read_out
);
    initial
    begin
        addr_out = '0;
        wdata_out = '0;
        write_out = 1'b0;
        read_out = 1'b0;
    end

    // wr waits for ready at a falling edge, then drives a one-cycle write
    // a ready that never comes is caught by the bench timeout
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        while (ready_in !== 1'b1)
        begin
            @(negedge core_clk_in);
        end
        addr_out = a;
        wdata_out = d;
        write_out = 1'b1;
        @(negedge core_clk_in);
        write_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask

    // write without waiting for ready, to probe refusal
    task automatic wr_now(input logic [9:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        addr_out = a;
        wdata_out = d;
        write_out = 1'b1;
        @(negedge core_clk_in);
        write_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask

    task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
        @(negedge core_clk_in);
        addr_out = a;
        read_out = 1'b1;
        @(negedge core_clk_in);
        d = rdata_in;
        v = rvalid_in;
        read_out = 1'b0;
        addr_out = ~a;
    endtask
endmodule

// ### clock_path_mode_config_tb_top.sv
`timescale 1ns/1ps
module clock_path_mode_config_tb_top;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic nvm_blank_in = 1'b1;
    logic [9:0] addr;
    logic [7:0] wdata, rdata;
    logic write, read, ready, rvalid;
    logic pdown, normal, neg, bypass, src, presc, busy;
    logic [2:0] ratio;
    logic [7:0] st;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    assign st = {1'b0, presc, src, bypass, neg, normal, pdown, busy};
    always #25 core_clk_in = ~core_clk_in;

    ccp_clock_path_cfg i_dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .nvm_blank_in(nvm_blank_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(write), .reg_read_in(read), .reg_ready_out(ready),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .pll_power_down_out(pdown),
        .pll_normal_out(normal), .pfd_negative_out(neg), .divider_ratio_code_out(ratio),
        .divider_bypass_out(bypass), .clk_source_sel_out(src),
        .prescaler_feed_out(presc), .nvm_busy_out(busy));
    ccp_host_model i_host (.core_clk_in(core_clk_in), .ready_in(ready), .rdata_in(rdata),
        .rvalid_in(rvalid), .addr_out(addr), .wdata_out(wdata), .write_out(write),
        .read_out(read));

    task automatic conclude();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk_rd(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host.rd(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask

    task automatic chk_cfg(input logic [7:0] p, input logic [7:0] dv, input logic [7:0] s);
        logic on;
        logic [7:0] exp_st;
        on = (p[1:0] == 2'h0);
        exp_st = {1'b0, on, ~s[0], s[0], p[7], on, p[1:0] == 2'h1, 1'b0};
        check(st, exp_st);
        check({5'h00, ratio}, {5'h00, dv[2:0]});
        chk_rd(ccp_pkg::PLL_CTRL_ADDR, p);
        chk_rd(ccp_pkg::DIV_RATIO_ADDR, dv);
        chk_rd(ccp_pkg::SRC_SEL_ADDR, s);
    endtask

    task automatic t_defaults();
        chk_cfg(8'h01, 8'h00, 8'h00);
    endtask

    task automatic reset_pulse();
        reset_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        reset_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
    endtask

    task automatic t_pll();
        logic [7:0] vals [4] = '{8'h00, 8'h80, 8'h81, 8'h01};
        foreach (vals[i])
        begin
            i_host.wr(ccp_pkg::PLL_CTRL_ADDR, vals[i]);
            chk_cfg(vals[i], 8'h00, 8'h00);
        end
    endtask

    task automatic t_source();
        i_host.wr(ccp_pkg::SRC_SEL_ADDR, 8'h01);
        chk_cfg(8'h01, 8'h00, 8'h01);
        for (int d = 0; d < 6; d++)
        begin
            i_host.wr(ccp_pkg::DIV_RATIO_ADDR, 8'(d));
            chk_rd(ccp_pkg::DIV_RATIO_ADDR, 8'(d));
        end
        i_host.wr(ccp_pkg::SRC_SEL_ADDR, 8'h00);
        chk_cfg(8'h01, 8'h05, 8'h00);
    endtask

    task automatic t_store();
        int n;
        i_host.wr(ccp_pkg::PLL_CTRL_ADDR, 8'h80);
        i_host.wr(ccp_pkg::DIV_RATIO_ADDR, 8'h03);
        i_host.wr(ccp_pkg::SRC_SEL_ADDR, 8'h01);
        i_host.wr(ccp_pkg::NVM_CMD_ADDR, 8'h01);
        n = 0;
        while (busy === 1'b1 && n < 20)
        begin
            n++;
            @(negedge core_clk_in);
        end
        check(8'(n), 8'(ccp_pkg::NVM_STORE_CYCLES));
        chk_rd(ccp_pkg::NVM_STATUS_ADDR, 8'h01);
        reset_pulse();
        chk_cfg(8'h80, 8'h03, 8'h01);
        chk_rd(10'h155, 8'h00);
    endtask

    // writes refused while storing; blanked image leaves defaults after reset
    task automatic t_busy();
        i_host.wr(ccp_pkg::NVM_CMD_ADDR, 8'h01);
        check({7'h00, ready}, 8'h00);
        i_host.wr_now(ccp_pkg::PLL_CTRL_ADDR, 8'h01);
        chk_rd(ccp_pkg::NVM_STATUS_ADDR, 8'h03);
        while (busy === 1'b1)
        begin
            @(negedge core_clk_in);
        end
        chk_rd(ccp_pkg::PLL_CTRL_ADDR, 8'h80);
        chk_rd(ccp_pkg::NVM_CMD_ADDR, 8'h00);
        nvm_blank_in = 1'b1;
        @(negedge core_clk_in);
        nvm_blank_in = 1'b0;
        chk_rd(ccp_pkg::NVM_STATUS_ADDR, 8'h00);
        reset_pulse();
        chk_cfg(8'h01, 8'h00, 8'h00);
    endtask

    initial
    begin
        repeat (8) @(negedge core_clk_in);
        reset_in = 1'b0;
        nvm_blank_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        t_defaults();
        t_pll();
        t_source();
        t_store();
        t_busy();
        conclude();
    end
endmodule
